// *** rtl/led_driver_i2c_register_slave.sv ***
// two-wire serial slave port with the led driver register space
//
// Notes on behaviour
// - answer five fixed upper address bits plus strap low bits, and broadcast address
// - eight-bit registers from zero through top address reachable over the port
// - standard and fast bit rates supported; master keeps within mode limit
// - data line only pulled low; pull-ups hold lines high when idle
// - start is data falling with clock high; stop is data rising
// - bus busy from detected start to detected stop
// - data changes only while clock low; one clock pulse per bit
// - eight bits per byte, most significant first, unlimited bytes
// - receiver drives ninth bit low to acknowledge, released for not-acknowledge
// - device may hold clock low after a byte, then releases it
// - first byte after start is seven address bits and direction bit
// - direction fixed per transaction; repeated start takes a new direction bit from the next address byte
// - byte after address byte is pointer; next byte stored there
// - further written bytes go to following registers until stop
// - read returns pointed register after pointer write and repeated start
// - each master acknowledge sends next register; not-acknowledge ends read
// - shutdown low ignores port and holds registers at reset values
module led_driver_i2c_register_slave (
  // system clock and reset
  input  wire logic                                   clock_in,
  input  wire logic                                   rst_b_in,
  // serial bus pins, clock pin also clocks the link shifter
  input  wire logic                                   scl_in,
  output logic                                        scl_out,
  output logic                                        scl_oe_out,
  input  wire logic                                   sda_in,
  output logic                                        sda_out,
  output logic                                        sda_oe_out,
  // straps and control pins
  input  wire logic [1:0]                             addr_sel_in,
  input  wire logic                                   shutdown_bar_pin_in,
  // register contents and bus state
  output logic [led_i2c_pkg::REG_COUNT*8-1:0]         reg_bank_out,
  output logic                                        bus_busy_out
);
  import led_i2c_pkg::*;

  logic [7:0]   link_shift_reg;
  logic [2:0]   scl_sync_reg;
  logic [2:0]   sda_sync_reg;
  logic [1:0]   sdb_sync_reg;
  logic [1:0]   addr_meta_reg;
  logic [1:0]   addr_sync_reg;
  link_state_t  state_reg;
  logic [3:0]   bit_cnt_reg;
  logic         read_sel_reg;
  logic [7:0]   ptr_reg;
  logic [7:0]   tx_reg;
  logic         sda_oe_reg;
  logic         scl_oe_reg;
  logic [2:0]   stretch_cnt_reg;
  logic         bus_busy_reg;
  logic [7:0]   mem_reg [0:REG_COUNT-1];
  logic [7:0]   rd_data;
  logic [2:0]   bit_idx;
  logic         tx_bit;
  logic         scl_now;
  logic         scl_prev;
  logic         sda_now;
  logic         sda_prev;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic         active;
  logic         in_range;
  logic         addr_match;
  logic         wr_en;
  logic [6:0]   own_addr;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: bits shifted in on the bus clock itself
  always_ff @(posedge scl_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link_shift_reg <= REG_RESET;
    end else begin
      link_shift_reg <= {link_shift_reg[6:0], sda_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; 50 MHz oversamples fast-mode edges many times over
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_sync_reg  <= 3'h7;
      sda_sync_reg  <= 3'h7;
      sdb_sync_reg  <= 2'h0;
      addr_meta_reg <= 2'h0;
      addr_sync_reg <= 2'h0;
    end else begin
      scl_sync_reg  <= {scl_sync_reg[1:0], scl_in};
      sda_sync_reg  <= {sda_sync_reg[1:0], sda_in};
      sdb_sync_reg  <= {sdb_sync_reg[0], shutdown_bar_pin_in};
      addr_meta_reg <= addr_sel_in;
      addr_sync_reg <= addr_meta_reg;
    end
  end

  assign scl_now   = scl_sync_reg[1];
  assign scl_prev  = scl_sync_reg[2];
  assign sda_now   = sda_sync_reg[1];
  assign sda_prev  = sda_sync_reg[2];
  assign scl_rise  = scl_now & ~scl_prev;
  assign scl_fall  = ~scl_now & scl_prev;
  assign start_det = scl_now & scl_prev & ~sda_now & sda_prev;
  assign stop_det  = scl_now & scl_prev & sda_now & ~sda_prev;
  assign active    = sdb_sync_reg[1];

  // the link byte is stable from the eighth rise until the next rise, microseconds later
  assign own_addr   = {SLAVE_ADDR_HI, addr_sync_reg};
  assign addr_match = (link_shift_reg[7:1] == own_addr) || (link_shift_reg[7:1] == BCAST_ADDR);
  assign in_range   = (ptr_reg <= REG_TOP);
  assign wr_en      = active && (state_reg == st_write) && scl_rise && (bit_cnt_reg == BIT_LAST);
  assign bit_idx    = 3'(BIT_LAST - bit_cnt_reg);
  assign tx_bit     = tx_reg[bit_idx];

  always_comb begin
    rd_data = OOR_READ;
    if (in_range) begin
      rd_data = mem_reg[ptr_reg[6:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus state
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus_busy_reg <= 1'b0;
    end else if (!active || stop_det) begin
      bus_busy_reg <= 1'b0;
    end else if (start_det) begin
      bus_busy_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transaction sequencer
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg    <= st_idle;
      bit_cnt_reg  <= CNT_ZERO;
      read_sel_reg <= 1'b0;
    end else if (!active || stop_det) begin
      state_reg   <= st_idle;
      bit_cnt_reg <= CNT_ZERO;
    end else if (start_det) begin
      state_reg   <= st_addr; // repeated start lands here too
      bit_cnt_reg <= CNT_ZERO;
    end else if (scl_rise) begin
      bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
      if (state_reg == st_addr && bit_cnt_reg == BIT_LAST) begin
        read_sel_reg <= link_shift_reg[0];
        if (!addr_match) begin
          state_reg <= st_idle;
        end
      end
      if (state_reg == st_read && bit_cnt_reg == BIT_ACK && sda_now) begin
        state_reg <= st_idle;
      end
    end else if (scl_fall && bit_cnt_reg == BIT_DONE) begin
      bit_cnt_reg <= CNT_ZERO;
      case (state_reg)
        st_addr: begin
          state_reg <= read_sel_reg ? st_read : st_ptr;
        end
        st_ptr: begin
          state_reg <= st_write;
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register pointer
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_reg <= PTR_RESET;
    end else if (!active) begin
      ptr_reg <= PTR_RESET;
    end else if (scl_rise && state_reg == st_ptr && bit_cnt_reg == BIT_LAST) begin
      ptr_reg <= link_shift_reg;
    end else if (wr_en) begin
      ptr_reg <= ptr_reg + PTR_STEP;
    end else if (scl_rise && state_reg == st_read && bit_cnt_reg == BIT_ACK && !sda_now) begin
      ptr_reg <= ptr_reg + PTR_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register space
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        mem_reg[i] <= REG_RESET;
      end
    end else if (!active) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        mem_reg[i] <= REG_RESET;
      end
    end else if (wr_en && in_range) begin
      mem_reg[ptr_reg[6:0]] <= link_shift_reg;
    end
  end

  for (genvar g = 0; g < REG_COUNT; g++) begin : g_bank
    assign reg_bank_out[g*8 +: 8] = mem_reg[g];
  end

  ////////////////////////////////////////////////////////////////////////////
  // data line driver; pulls low only after a seen clock fall, released on start, stop or shutdown
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sda_oe_reg <= 1'b0;
      tx_reg     <= REG_RESET;
    end else if (!active || start_det || stop_det) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall) begin
      if (bit_cnt_reg == BIT_DONE) begin
        if ((state_reg == st_addr && read_sel_reg) || state_reg == st_read) begin
          tx_reg     <= rd_data;
          sda_oe_reg <= ~rd_data[7];
        end else begin
          sda_oe_reg <= 1'b0;
        end
      end else if (bit_cnt_reg == BIT_ACK) begin
        // out-of-range writes still acknowledged
        sda_oe_reg <= (state_reg == st_addr) || (state_reg == st_ptr) || (state_reg == st_write);
      end else if (state_reg == st_read && bit_cnt_reg != CNT_ZERO) begin
        sda_oe_reg <= ~tx_bit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // short clock hold after each acknowledged byte slot to cover register fetch
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stretch_cnt_reg <= STRETCH_ZERO;
      scl_oe_reg      <= 1'b0;
    end else if (!active) begin
      stretch_cnt_reg <= STRETCH_ZERO;
      scl_oe_reg      <= 1'b0;
    end else if (scl_fall && bit_cnt_reg == BIT_DONE && state_reg != st_idle) begin
      stretch_cnt_reg <= STRETCH_CYC;
      scl_oe_reg      <= 1'b1;
    end else if (stretch_cnt_reg != STRETCH_ZERO) begin
      stretch_cnt_reg <= stretch_cnt_reg - STRETCH_ONE;
      scl_oe_reg      <= (stretch_cnt_reg != STRETCH_ONE);
    end
  end

  // open drain: only ever drive low
  assign sda_out      = 1'b0;
  assign scl_out      = 1'b0;
  assign sda_oe_out   = sda_oe_reg;
  assign scl_oe_out   = scl_oe_reg;
  assign bus_busy_out = bus_busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  sda_edge_a: assert property ($rose(sda_oe_reg) |-> !scl_prev)
    else $error("data line driven low while clock high");
  start_busy_a: assert property ((start_det && active) |=> bus_busy_reg)
    else $error("bus not busy after start");
  stop_free_a: assert property (stop_det |=> !bus_busy_reg ##1 !bus_busy_reg)
    else $error("bus still busy after stop");
  addr_ack_a: assert property ((active && state_reg == st_addr && scl_fall && bit_cnt_reg == BIT_ACK)
    |=> sda_oe_reg)
    else $error("matched address not acknowledged");
  ptr_step_a: assert property (wr_en |=> ptr_reg == $past(ptr_reg) + PTR_STEP)
    else $error("pointer did not advance after write");
  write_store_a: assert property ((wr_en && ptr_reg == PTR_RESET) |=> mem_reg[0] == $past(link_shift_reg))
    else $error("written byte not stored");
  beyond_top_a: assert property (!in_range |-> rd_data == OOR_READ)
    else $error("out of range read not zero");
  shutdown_hold_a: assert property (!active |=> (state_reg == st_idle && !sda_oe_reg && mem_reg[0] == REG_RESET))
    else $error("port active during shutdown");
  read_bit_a: assert property ((active && state_reg == st_read && scl_fall && bit_cnt_reg != CNT_ZERO
    && bit_cnt_reg < BIT_ACK) |=> sda_oe_reg == !$past(tx_bit))
    else $error("wrong read bit driven");
  read_nack_a: assert property ((active && state_reg == st_read && scl_rise && bit_cnt_reg == BIT_ACK
    && sda_now) |=> state_reg == st_idle)
    else $error("read continued after not-acknowledge");
  stretch_len_a: assert property ((active && $rose(scl_oe_reg)) |-> scl_oe_reg[*4] ##1 !scl_oe_reg)
    else $error("clock hold length wrong");

  write_seen_c: cover property (wr_en && in_range);
  read_seen_c: cover property (state_reg == st_read && scl_fall && bit_cnt_reg == BIT_DONE);
  bcast_seen_c: cover property (state_reg == st_addr && scl_rise && bit_cnt_reg == BIT_LAST
    && link_shift_reg[7:1] == BCAST_ADDR);
  nack_seen_c: cover property (state_reg == st_read && scl_rise && bit_cnt_reg == BIT_ACK && sda_now);

endmodule : led_driver_i2c_register_slave

// *** rtl/led_i2c_pkg.sv ***
// shared constants and types for the led driver serial register port
package led_i2c_pkg;

  localparam int          CLK_PERIOD_NS  = 20;
  localparam int          STD_RATE_KBPS  = 100;
  localparam int          FAST_RATE_KBPS = 400;

  // slave addressing
  localparam logic [4:0]  SLAVE_ADDR_HI  = 5'h0C;
  localparam logic [6:0]  BCAST_ADDR     = 7'h1C;

  // register space
  localparam logic [7:0]  REG_TOP        = 8'h5D;
  localparam int          REG_COUNT      = 94;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  OOR_READ       = 8'h00;
  localparam logic [7:0]  PTR_RESET      = 8'h00;
  localparam logic [7:0]  PTR_STEP       = 8'h01;

  // bit counter marks: rises seen within one byte slot
  localparam logic [3:0]  CNT_ZERO       = 4'h0;
  localparam logic [3:0]  CNT_ONE        = 4'h1;
  localparam logic [3:0]  BIT_LAST       = 4'h7;
  localparam logic [3:0]  BIT_ACK        = 4'h8;
  localparam logic [3:0]  BIT_DONE       = 4'h9;

  // clock hold after each acknowledged byte slot, least time rounds up
  localparam int          STRETCH_NS     = 80;
  localparam int          STRETCH_CYC_I  = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  STRETCH_CYC    = 3'(STRETCH_CYC_I);
  localparam logic [2:0]  STRETCH_ONE    = 3'h1;
  localparam logic [2:0]  STRETCH_ZERO   = 3'h0;

  typedef enum logic [2:0] {st_idle, st_addr, st_ptr, st_write, st_read} link_state_t;

endpackage : led_i2c_pkg

// *** testbench/i2c_master_model.sv ***
// bus master model: bit-banged open-drain master with clock-hold awareness
module i2c_master_model (
  // open-drain pulls, high means line pulled low
  output logic      scl_low_out,
  output logic      sda_low_out,
  // resolved wire levels
  input  wire logic scl_in,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // 2.5 us per bit keeps within the 400 kbit/s fast-mode limit, low and high both legal
  localparam time HALF = 1250ns;
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // released lines float high through pull-ups, so no stale level survives
  task automatic rel_scl();
    scl_low_out = 1'b0;
    wait (scl_in === 1'b1); // device may still hold the clock low
  endtask : rel_scl
  task automatic start();
    sda_low_out = 1'b0;
    #HALF;
    rel_scl();
    #HALF;
    sda_low_out = 1'b1; // data falls with clock high
    #HALF;
    scl_low_out = 1'b1;
  endtask : start
  task automatic stop();
    #(HALF/2);
    sda_low_out = 1'b1;
    #(HALF/2);
    rel_scl();
    #HALF;
    sda_low_out = 1'b0; // data rises with clock high
    #HALF;
  endtask : stop
  // data moves only mid-low, away from the clock edges
  task automatic bit_io(input logic b, output logic r);
    #(HALF/2);
    sda_low_out = !b;
    #(HALF/2);
    rel_scl();
    #(HALF/2);
    r = sda_in;
    #(HALF/2);
    scl_low_out = 1'b1;
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r); // msb first
    bit_io(1'b1, r); // released for the receiver's answer
    ack = !r;
  endtask : wr_byte
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, r); // nack on the last byte
  endtask : rd_byte
endmodule : i2c_master_model

// *** testbench/led_driver_i2c_register_slave_bench.sv ***
// self-checking bench for the led driver serial register port
module led_driver_i2c_register_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import led_i2c_pkg::*;
  logic                  clock_in = 1'b0;
  logic                  rst_b_in = 1'b0;
  logic [1:0]            addr_sel = 2'h0;
  logic                  shutdown_b = 1'b1;
  logic                  m_scl_low, m_sda_low, scl_oe, sda_oe, busy;
  logic [REG_COUNT*8-1:0] bank;
  wire                   scl_w = !(m_scl_low | scl_oe);
  wire                   sda_w = !(m_sda_low | sda_oe);
  int                    n_errors = 0;
  int                    total_checks = 0;
  int                    cycles = 0;
  always #10 clock_in = !clock_in;
  led_driver_i2c_register_slave uut (.clock_in(clock_in), .rst_b_in(rst_b_in), .scl_in(scl_w), .scl_out(),
    .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(), .sda_oe_out(sda_oe), .addr_sel_in(addr_sel),
    .shutdown_bar_pin_in(shutdown_b), .reg_bank_out(bank), .bus_busy_out(busy));
  i2c_master_model m (.scl_low_out(m_scl_low), .sda_low_out(m_sda_low), .scl_in(scl_w), .sda_in(sda_w));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask : step
  function automatic logic [7:0] rg(input int n);
    return bank[n*8 +: 8];
  endfunction : rg
  task automatic send(input logic [7:0] b, input logic exp);
    logic ack;
    m.wr_byte(b, ack);
    check8({7'h00, ack}, {7'h00, exp});
  endtask : send
  task automatic rd(input logic more, input logic [7:0] exp);
    logic [7:0] d;
    m.rd_byte(more, d);
    check8(d, exp);
  endtask : rd
  task automatic wr1(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, input logic ok);
    m.start();
    send({a, 1'b0}, ok);
    if (ok) send(p, 1'b1);
    if (ok) send(d, 1'b1);
    m.stop();
  endtask : wr1
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check8({7'h00, busy}, 8'h00);
    for (int n = 0; n < REG_COUNT; n++) check8(rg(n), REG_RESET);
  endtask : t_reset
  task automatic t_multi_write();
    m.start();
    step(10);
    check8({7'h00, busy}, 8'h01);
    send(8'h60, 1'b1);
    send(8'h5C, 1'b1);
    send(8'hA5, 1'b1);
    send(8'h3C, 1'b1);
    send(8'h77, 1'b1);
    m.stop();
    step(10);
    check8({7'h00, busy}, 8'h00);
    check8(rg(8'h5C), 8'hA5);
    check8(rg(8'h5D), 8'h3C);
    check8(rg(8'h00), 8'h00);
  endtask : t_multi_write
  task automatic t_multi_read();
    m.start();
    send(8'h60, 1'b1);
    send(8'h5C, 1'b1);
    m.start(); // repeated start turns the direction
    send(8'h61, 1'b1);
    rd(1'b1, 8'hA5);
    rd(1'b1, 8'h3C);
    rd(1'b0, OOR_READ);
    m.stop();
  endtask : t_multi_read
  task automatic t_address();
    for (int s = 0; s < 4; s++) begin
      addr_sel = 2'(s);
      step(5);
      wr1({SLAVE_ADDR_HI, 2'(s)} ^ 7'h01, 8'h20, 8'hEE, 1'b0);
      wr1({SLAVE_ADDR_HI, 2'(s)}, 8'h10 + 8'(s), 8'h80 | 8'(s), 1'b1);
      check8(rg(16 + s), 8'h80 | 8'(s));
    end
    wr1(BCAST_ADDR, 8'h01, 8'h5A, 1'b1);
    check8(rg(1), 8'h5A);
    check8(rg(8'h20), 8'h00);
  endtask : t_address
  task automatic t_shutdown();
    step(1);
    shutdown_b = 1'b0;
    step(5);
    check8(rg(1), REG_RESET);
    check8(rg(8'h5C), REG_RESET);
    wr1({SLAVE_ADDR_HI, 2'h3}, 8'h02, 8'h11, 1'b0);
    check8(rg(2), REG_RESET);
    shutdown_b = 1'b1;
    step(5);
    wr1({SLAVE_ADDR_HI, 2'h3}, 8'h02, 8'h11, 1'b1);
    check8(rg(2), 8'h11);
  endtask : t_shutdown
  initial begin
    step(5);
    rst_b_in = 1'b1;
    t_reset();
    step(10000); // host waits 200 us before first access
    t_multi_write();
    t_multi_read();
    t_address();
    t_shutdown();
    stop_test();
  end
endmodule : led_driver_i2c_register_slave_bench
